// ### logic/pkt_count_pkg.sv
// Purpose: Shared constants and carriers for the receive packet counters.
// Assumes: 32-bit APB data, 16-bit registers in the low half of each word.
// Notes: Register indices are multiplied by four to form byte addresses.
package pkt_count_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int DATA_W = 16;
    localparam int NUM_EP = 7;
    localparam int NUM_PORTS = 2;
    localparam int IRQ_W = 2;
    localparam int ADDR_W = 12;

    ////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is index times four)
    localparam logic [9:0] IDX_PORT0_COUNT = 10'h04E;
    localparam logic [9:0] IDX_PORT1_COUNT = 10'h056;
    localparam logic [9:0] IDX_BUF_STATUS = 10'h058;
    localparam logic [9:0] IDX_PORT0_CTRL = 10'h060;
    localparam logic [9:0] IDX_PORT1_CTRL = 10'h061;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h062;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h063;

    ////////////////////////////////////////////////////////////////////////
    // Port control register fields
    localparam int CTRL_CLEAR_BIT = 15;
    localparam int CTRL_ENABLE_BIT = 14;
    localparam int CTRL_DIR_BIT = 13;
    localparam int CTRL_CONT_BIT = 12;
    localparam int CTRL_TYPE_LSB = 10;
    localparam logic [1:0] TYPE_BULK = 2'h1;
    localparam logic DIR_OUT = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status bits
    localparam int IRQ_DONE0_BIT = 0;
    localparam int IRQ_DONE1_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [NUM_EP-1:0] BUF_STATUS_RST = 7'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [31:0] PRDATA_RST = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic enable;
        logic dir;
        logic cont;
        logic [1:0] ttype;
    } port_ctrl_t;

    localparam port_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, 2'h0};

    typedef struct packed {
        logic clear;
        logic load;
        logic [DATA_W-1:0] wdata;
        logic pkt;
        logic normal_done;
    } cnt_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage : pkt_count_pkg

// ### logic/pkt_counter_unit.sv
// Purpose: One packet counter with target compare for a DMA FIFO port.
// Assumes: Load and clear requests are single-cycle pulses from the register block; normal_done may stay high.
// Notes: Completion pulse is emitted on the rising edge of the condition.
`timescale 1ns/1ps
module pkt_counter_unit #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pkt_count_pkg::port_ctrl_t ctrl,
    input wire pkt_count_pkg::cnt_req_t req,
    output logic [W-1:0] rd_value,
    output logic done_pulse
);

    typedef struct packed {
        logic [W-1:0] target;
        logic [W-1:0] current;
        logic cond_seen;
        logic done_pulse;
    } unit_state_t;

    unit_state_t st_r;
    unit_state_t st_nxt;
    logic eligible;
    logic counting;
    logic match;
    logic cond;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        eligible = (ctrl.dir == pkt_count_pkg::DIR_OUT) && ctrl.cont
            && (ctrl.ttype == pkt_count_pkg::TYPE_BULK);
        counting = ctrl.enable && eligible;
        match = counting && (st_r.current == st_r.target);
        cond = match || req.normal_done;
        st_nxt = st_r;
        if (req.load) begin
            st_nxt.target = req.wdata;
        end
        if (req.clear) begin
            st_nxt.current = '0;
        end else if (req.pkt && counting && !match) begin
            // Freezing at the match keeps the readback equal to the target
            st_nxt.current = W'(st_r.current + 1'b1);
        end
        st_nxt.done_pulse = cond && !st_r.cond_seen;
        st_nxt.cond_seen = cond;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Readback follows the enable bit, not the endpoint qualification
    assign rd_value = ctrl.enable ? st_r.current : st_r.target;
    assign done_pulse = st_r.done_pulse;

endmodule : pkt_counter_unit

// ### logic/dma_receive_packet_counter.sv
// Purpose: Receive packet counters for two DMA FIFO ports plus the
//          endpoint buffer-ready status word, behind an APB slave.
// Assumes: pkt_rx inputs are synchronous one-cycle pulses; normal_done may stay high.
// Notes: APB answers with one wait state; unmapped addresses get pslverr.
`timescale 1ns/1ps
module dma_receive_packet_counter #(
    parameter int NUM_EP = pkt_count_pkg::NUM_EP,
    parameter int CNT_W = pkt_count_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sw_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pkt_count_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pkt_count_pkg::NUM_PORTS-1:0] pkt_rx,
    input wire logic [pkt_count_pkg::NUM_PORTS-1:0] normal_done,
    input wire logic [NUM_EP-1:0] buf_ready_set,
    input wire logic [NUM_EP-1:0] buf_ready_clr,
    output logic [pkt_count_pkg::NUM_PORTS-1:0] rx_complete,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // State

    // Every flop of the block outside the two counter units lives in this one image
    typedef struct packed {
        pkt_count_pkg::bus_state_t bus_st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        pkt_count_pkg::port_ctrl_t ctrl0;
        pkt_count_pkg::port_ctrl_t ctrl1;
        logic [NUM_EP-1:0] buf_status;
        logic [pkt_count_pkg::IRQ_W-1:0] irq_status;
        logic [pkt_count_pkg::IRQ_W-1:0] irq_mask;
        logic irq;
        logic [pkt_count_pkg::NUM_PORTS-1:0] complete;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;
    pkt_count_pkg::cnt_req_t req0;
    pkt_count_pkg::cnt_req_t req1;
    logic [CNT_W-1:0] rd0;
    logic [CNT_W-1:0] rd1;
    logic done0;
    logic done1;
    logic commit;
    logic wr_commit;
    logic [pkt_count_pkg::IRQ_W-1:0] irq_events;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // A low address bit set never matches, so misaligned access errs
    function automatic logic idx_hit(
        input logic [pkt_count_pkg::ADDR_W-1:0] addr,
        input logic [9:0] idx
    );
        idx_hit = (addr[pkt_count_pkg::ADDR_W-1:2] == idx)
            && (addr[1:0] == 2'h0);
    endfunction : idx_hit

    function automatic logic [15:0] ctrl_word(
        input pkt_count_pkg::port_ctrl_t c
    );
        logic [15:0] w;
        w = 16'h0000;
        // Count clear is never stored, so it always reads back as zero
        w[pkt_count_pkg::CTRL_ENABLE_BIT] = c.enable;
        w[pkt_count_pkg::CTRL_DIR_BIT] = c.dir;
        w[pkt_count_pkg::CTRL_CONT_BIT] = c.cont;
        w[pkt_count_pkg::CTRL_TYPE_LSB +: 2] = c.ttype;
        ctrl_word = w;
    endfunction : ctrl_word

    function automatic pkt_count_pkg::port_ctrl_t ctrl_load(
        input logic [31:0] d
    );
        pkt_count_pkg::port_ctrl_t c;
        // The clear bit is not stored; it only pulses the counter
        c.enable = d[pkt_count_pkg::CTRL_ENABLE_BIT];
        c.dir = d[pkt_count_pkg::CTRL_DIR_BIT];
        c.cont = d[pkt_count_pkg::CTRL_CONT_BIT];
        c.ttype = d[pkt_count_pkg::CTRL_TYPE_LSB +: 2];
        ctrl_load = c;
    endfunction : ctrl_load

    function automatic logic mapped(
        input logic [pkt_count_pkg::ADDR_W-1:0] addr
    );
        mapped = idx_hit(addr, pkt_count_pkg::IDX_PORT0_COUNT)
            || idx_hit(addr, pkt_count_pkg::IDX_PORT1_COUNT)
            || idx_hit(addr, pkt_count_pkg::IDX_BUF_STATUS)
            || idx_hit(addr, pkt_count_pkg::IDX_PORT0_CTRL)
            || idx_hit(addr, pkt_count_pkg::IDX_PORT1_CTRL)
            || idx_hit(addr, pkt_count_pkg::IDX_IRQ_STATUS)
            || idx_hit(addr, pkt_count_pkg::IDX_IRQ_MASK);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // Counter requests

    // The write lands on the edge where the master sees pready high
    assign commit = psel && penable && st_r.pready;
    assign wr_commit = commit && pwrite && !st_r.pslverr;

    // Both units see the write data; only the addressed one acts on it
    always_comb begin
        req0 = '0;
        req1 = '0;
        req0.wdata = pwdata[CNT_W-1:0];
        req1.wdata = pwdata[CNT_W-1:0];
        req0.pkt = pkt_rx[0];
        req1.pkt = pkt_rx[1];
        req0.normal_done = normal_done[0];
        req1.normal_done = normal_done[1];
        if (wr_commit) begin
            req0.load = idx_hit(paddr, pkt_count_pkg::IDX_PORT0_COUNT);
            req1.load = idx_hit(paddr, pkt_count_pkg::IDX_PORT1_COUNT);
            // Writing zero to the clear bit has no effect
            req0.clear = idx_hit(paddr, pkt_count_pkg::IDX_PORT0_CTRL)
                && pwdata[pkt_count_pkg::CTRL_CLEAR_BIT];
            req1.clear = idx_hit(paddr, pkt_count_pkg::IDX_PORT1_CTRL)
                && pwdata[pkt_count_pkg::CTRL_CLEAR_BIT];
        end
    end

    pkt_counter_unit #(
        .W(CNT_W)
    ) u_count0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ctrl(st_r.ctrl0),
        .req(req0),
        .rd_value(rd0),
        .done_pulse(done0)
    );

    pkt_counter_unit #(
        .W(CNT_W)
    ) u_count1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ctrl(st_r.ctrl1),
        .req(req1),
        .rd_value(rd1),
        .done_pulse(done1)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        irq_events = '0;
        irq_events[pkt_count_pkg::IRQ_DONE0_BIT] = done0;
        irq_events[pkt_count_pkg::IRQ_DONE1_BIT] = done1;
        // One more flop so the completion output leaves a register
        st_nxt.complete = {done1, done0};

        // Buffer ready: set wins over clear in the same cycle
        st_nxt.buf_status = (st_r.buf_status & ~buf_ready_clr)
            | buf_ready_set;
        if (sw_rst) begin
            st_nxt.buf_status = pkt_count_pkg::BUF_STATUS_RST;
        end

        case (st_r.bus_st)
            pkt_count_pkg::BUS_IDLE: begin
                st_nxt.pready = 1'b0;
                st_nxt.pslverr = 1'b0;
                if (psel && penable) begin
                    st_nxt.bus_st = pkt_count_pkg::BUS_ACK;
                    st_nxt.pready = 1'b1;
                    st_nxt.pslverr = !mapped(paddr);
                    st_nxt.prdata = pkt_count_pkg::PRDATA_RST;
                    // Captured a cycle early so prdata stands with pready
                    if (!pwrite) begin
                        if (idx_hit(paddr, pkt_count_pkg::IDX_PORT0_COUNT))
                        begin
                            st_nxt.prdata[CNT_W-1:0] = rd0;
                        end
                        if (idx_hit(paddr, pkt_count_pkg::IDX_PORT1_COUNT))
                        begin
                            st_nxt.prdata[CNT_W-1:0] = rd1;
                        end
                        if (idx_hit(paddr, pkt_count_pkg::IDX_BUF_STATUS))
                        begin
                            // Upper bits always read zero
                            st_nxt.prdata[NUM_EP-1:0] =
                                st_r.buf_status;
                        end
                        if (idx_hit(paddr, pkt_count_pkg::IDX_PORT0_CTRL))
                        begin
                            st_nxt.prdata[15:0] = ctrl_word(st_r.ctrl0);
                        end
                        if (idx_hit(paddr, pkt_count_pkg::IDX_PORT1_CTRL))
                        begin
                            st_nxt.prdata[15:0] = ctrl_word(st_r.ctrl1);
                        end
                        if (idx_hit(paddr, pkt_count_pkg::IDX_IRQ_STATUS))
                        begin
                            st_nxt.prdata[pkt_count_pkg::IRQ_W-1:0] =
                                st_r.irq_status;
                        end
                        if (idx_hit(paddr, pkt_count_pkg::IDX_IRQ_MASK))
                        begin
                            st_nxt.prdata[pkt_count_pkg::IRQ_W-1:0] =
                                st_r.irq_mask;
                        end
                    end
                end
            end
            pkt_count_pkg::BUS_ACK: begin
                st_nxt.bus_st = pkt_count_pkg::BUS_IDLE;
                st_nxt.pready = 1'b0;
                st_nxt.pslverr = 1'b0;
                if (wr_commit) begin
                    if (idx_hit(paddr, pkt_count_pkg::IDX_PORT0_CTRL)) begin
                        st_nxt.ctrl0 = ctrl_load(pwdata);
                    end
                    if (idx_hit(paddr, pkt_count_pkg::IDX_PORT1_CTRL)) begin
                        st_nxt.ctrl1 = ctrl_load(pwdata);
                    end
                    if (idx_hit(paddr, pkt_count_pkg::IDX_IRQ_MASK)) begin
                        st_nxt.irq_mask = pwdata[pkt_count_pkg::IRQ_W-1:0];
                    end
                end
                // Only bits already returned are cleared, so an event that
                // lands between capture and completion is not lost
                if (commit && !pwrite
                    && idx_hit(paddr, pkt_count_pkg::IDX_IRQ_STATUS)) begin
                    st_nxt.irq_status = st_r.irq_status
                        & ~st_r.prdata[pkt_count_pkg::IRQ_W-1:0];
                end
            end
            // Stray one-hot codes fall back to idle
            default: begin
                st_nxt.bus_st = pkt_count_pkg::BUS_IDLE;
                st_nxt.pready = 1'b0;
                st_nxt.pslverr = 1'b0;
            end
        endcase

        // New events win over a read clear
        st_nxt.irq_status = st_nxt.irq_status | irq_events;
        // Level stays up until a read clears or the mask hides the bit
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Soft reset is handled in next state; it only touches buffer status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.bus_st <= pkt_count_pkg::BUS_IDLE;
            st_r.pready <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.prdata <= pkt_count_pkg::PRDATA_RST;
            st_r.ctrl0 <= pkt_count_pkg::CTRL_RST;
            st_r.ctrl1 <= pkt_count_pkg::CTRL_RST;
            st_r.buf_status <= pkt_count_pkg::BUF_STATUS_RST;
            st_r.irq_status <= pkt_count_pkg::IRQ_RST;
            st_r.irq_mask <= pkt_count_pkg::IRQ_RST;
            st_r.irq <= 1'b0;
            st_r.complete <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign rx_complete = st_r.complete;
    assign irq = st_r.irq;

endmodule : dma_receive_packet_counter

// ### testbench/dma_receive_packet_counter_sva.sv
// Purpose: Port level checks of bus answers, completion and interrupt.
// Assumes: One clock domain, sys_rst active high and asynchronous.
// Notes: Internal state is unseen, so checks tie outputs to port causes.
`timescale 1ns/1ps
module dma_receive_packet_counter_chk #(
    parameter int NUM_EP = pkt_count_pkg::NUM_EP,
    parameter int CNT_W = pkt_count_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sw_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pkt_count_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [pkt_count_pkg::NUM_PORTS-1:0] pkt_rx,
    input wire logic [pkt_count_pkg::NUM_PORTS-1:0] normal_done,
    input wire logic [NUM_EP-1:0] buf_ready_set,
    input wire logic [NUM_EP-1:0] buf_ready_clr,
    input wire logic [pkt_count_pkg::NUM_PORTS-1:0] rx_complete,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    wait_state_a: assert property (
        psel && penable && !pready |=> pready) else $error("answer late");
    ready_cause_a: assert property (
        pready |-> $past(psel && penable && !pready))
        else $error("answer without request");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("answer held too long");
    err_refuse_a: assert property (
        pslverr |-> pready && prdata == 32'h00000000)
        else $error("refusal malformed");
    upper_zero_a: assert property (
        pready |-> prdata[31:16] == 16'h0000) else $error("upper half set");

    ////////////////////////////////////////////////////////////////////////
    // Completion fires once per rising condition
    done_once_a: assert property (
        rx_complete[0] |=> !rx_complete[0]) else $error("port0 done held");
    done_fall_a: assert property (
        $rose(rx_complete[1]) |=> $fell(rx_complete[1]))
        else $error("port1 done held");
    done_hold_a: assert property (
        normal_done[1] [*4] |-> !rx_complete[1])
        else $error("repeat done on steady condition");

    ////////////////////////////////////////////////////////////////////////
    // Interrupt level moves only on an event or a register access
    irq_cause_a: assert property (
        $rose(irq) |-> rx_complete != 2'h0 || $past(pready && pwrite))
        else $error("interrupt without cause");
    irq_drop_a: assert property (
        $fell(irq) |-> $past(pready)) else $error("interrupt dropped alone");

    cover property (rx_complete[0]);
    cover property (pslverr);
    cover property (normal_done[1] [*4]);
endmodule : dma_receive_packet_counter_chk

bind dma_receive_packet_counter dma_receive_packet_counter_chk #(
    .NUM_EP(NUM_EP), .CNT_W(CNT_W)
) u_chk (
    .clk(clk), .sys_rst(sys_rst), .sw_rst(sw_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_rx(pkt_rx),
    .normal_done(normal_done), .buf_ready_set(buf_ready_set),
    .buf_ready_clr(buf_ready_clr), .rx_complete(rx_complete), .irq(irq)
);

// ### testbench/dma_drain_model.sv
// Purpose: DMA side that signals received packets and normal completion.
// Assumes: Packets arrive at least one idle cycle apart.
// Notes: Gap argument selects prompt or slow traffic.
`timescale 1ns/1ps
module dma_drain_model (
    input wire logic clk,
    output logic [1:0] pkt_rx,
    output logic [1:0] normal_done
);
    initial begin
        pkt_rx = 2'h0;
        normal_done = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One cycle pulse per packet, then gap idle cycles
    task automatic send(input int p, input int n, input int gap);
        repeat (n) begin
            pkt_rx[p] <= 1'h1;
            @(posedge clk);
            pkt_rx[p] <= 1'h0;
            repeat (gap) @(posedge clk);
        end
    endtask : send

    task automatic hold(input int p, input int n);
        normal_done[p] <= 1'h1;
        repeat (n) @(posedge clk);
        normal_done[p] <= 1'h0;
    endtask : hold
endmodule : dma_drain_model

// ### testbench/test_dma_receive_packet_counter.sv
// Purpose: Self-checking bench for the receive packet counters.
// Assumes: Bus answer timing is taken from pready, never assumed.
// Notes: Expected values come from an integer model kept in this bench.
`timescale 1ns/1ps
module test_dma_receive_packet_counter;
    logic clk, sys_rst, sw_rst, psel, penable, pwrite, pready, pslverr;
    logic irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] pkt_rx, normal_done, rx_complete;
    logic [6:0] bset, bclr, bs;
    logic [15:0] lfsr_r, v;
    int failures, samples_checked, tgt[2], cur[2], dexp[2], dseen[2];
    bit en[2], act[2];
    logic [11:0] a_cnt[2] = '{{pkt_count_pkg::IDX_PORT0_COUNT, 2'h0},
        {pkt_count_pkg::IDX_PORT1_COUNT, 2'h0}};
    logic [11:0] a_ctl[2] = '{{pkt_count_pkg::IDX_PORT0_CTRL, 2'h0},
        {pkt_count_pkg::IDX_PORT1_CTRL, 2'h0}};
    logic [15:0] bad[5] = '{16'h7400, 16'h4400, 16'h5000, 16'h5800, 16'h5C00};
    localparam logic [11:0] A_STS = {pkt_count_pkg::IDX_BUF_STATUS, 2'h0};
    localparam logic [11:0] A_IRQ = {pkt_count_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_MSK = {pkt_count_pkg::IDX_IRQ_MASK, 2'h0};

    always #2.5 clk = ~clk;

    dma_receive_packet_counter dut (
        .clk(clk), .sys_rst(sys_rst), .sw_rst(sw_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_rx(pkt_rx),
        .normal_done(normal_done), .buf_ready_set(bset),
        .buf_ready_clr(bclr), .rx_complete(rx_complete), .irq(irq)
    );
    dma_drain_model u_dma (
        .clk(clk), .pkt_rx(pkt_rx), .normal_done(normal_done)
    );

    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (rx_complete[i] === 1'h1) dseen[i] <= dseen[i] + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic final_report;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 40);
        r = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 40) begin
            failures++;
            final_report();
        end
        // Idle edge so the next setup never reassigns psel in this step
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'h1, a, {16'h0000, d});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
        input string n);
        apb(1'h0, a, 32'h00000000);
        chk(n, e, r);
    endtask : rd

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic rnd;
        lfsr_r = lfsr_next(lfsr_r);
        v = lfsr_r;
    endtask : rnd

    task automatic ctl(input int p, input logic [15:0] d);
        wr(a_ctl[p], d);
        en[p] = d[14];
        act[p] = d[14] && !d[13] && d[12] && d[11:10] == 2'h1;
        if (d[15]) cur[p] = 0;
    endtask : ctl

    // Model stops counting at the match and counts one completion there
    task automatic pkts(input int p, input int n, input int gap);
        u_dma.send(p, n, gap);
        for (int i = 0; i < n; i++) begin
            if (act[p] && cur[p] != tgt[p]) begin
                cur[p]++;
                if (cur[p] == tgt[p]) dexp[p]++;
            end
        end
    endtask : pkts

    task automatic cnt(input int p);
        rd(a_cnt[p], en[p] ? cur[p] : tgt[p], "count");
    endtask : cnt

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {clk, psel, penable, pwrite, sw_rst} = 5'h00;
        sys_rst = 1'h1;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        {bset, bclr, bs} = 21'h000000;
        lfsr_r = 16'h3A4E;
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        cnt(0);
        cnt(1);
        rd(A_STS, 32'h00000000, "status reset");
        wr(A_MSK, 16'h0003);
        rd(A_MSK, 32'h00000003, "mask");
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            rnd();
            tgt[p] = 3 + v[1:0];
            wr(a_cnt[p], 16'(tgt[p]));
            cnt(p);
            ctl(p, 16'h5400);
            cnt(p);
            pkts(p, tgt[p] + 2, p * 6 + 1);
            repeat (6) @(posedge clk);
            cnt(p);
            chk("done count", dexp[p], dseen[p]);
            chk("irq set", 32'h00000001, irq);
            rd(A_IRQ, 32'(1 << p), "irq status");
            @(posedge clk);
            chk("irq cleared", 32'h00000000, irq);
            ctl(p, 16'hD400);
            cnt(p);
            rd(a_ctl[p], 32'h00005400, "ctrl");
            for (int i = 0; i < 5; i++) begin
                ctl(p, bad[i]);
                pkts(p, 2, 1);
                cnt(p);
            end
            ctl(p, 16'h0000);
            cnt(p);
            chk("done count", dexp[p], dseen[p]);
            $display("test port %0d done", p);
        end
        u_dma.hold(1, 5);
        dexp[1]++;
        repeat (4) @(posedge clk);
        chk("normal done", dexp[1], dseen[1]);
        rd(A_IRQ, 32'h00000002, "irq status");
        $display("test normal completion done");
        for (int i = 0; i < 12; i++) begin
            rnd();
            bset <= v[6:0];
            bclr <= v[13:7];
            @(posedge clk);
            bset <= 7'h00;
            bclr <= 7'h00;
            bs = (bs & ~v[13:7]) | v[6:0];
            rd(A_STS, {25'h0000000, bs}, "status");
        end
        wr(A_STS, {9'h000, ~bs});
        rd(A_STS, {25'h0000000, bs}, "status read only");
        sw_rst <= 1'h1;
        @(posedge clk);
        sw_rst <= 1'h0;
        bs = 7'h00;
        rd(A_STS, 32'h00000000, "status soft reset");
        $display("test status done");
        apb(1'h0, 12'h1FC, 32'h00000000);
        chk("unmapped flag", 32'h00000001, er);
        chk("unmapped data", 32'h00000000, r);
        apb(1'h0, 12'h139, 32'h00000000);
        chk("misaligned flag", 32'h00000001, er);
        $display("test refusal done");
        final_report();
    end
endmodule : test_dma_receive_packet_counter
